// ---- misc_ctrl.sv ----
// Top: miscellaneous control register, bus clock selection, external
// interrupt config, reset pin driver and port direction defaults.
// Assumes an Avalon-MM master on core_clk and async pins from the board.
module misc_ctrl
   import misc_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic irq_pin_n,
   input wire logic reset_pin_n_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   input wire logic cpu_irq_masked,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic watchdog_fault,
   output logic bus_tick,
   output logic bus_clk_level,
   output logic halted,
   output logic ext_irq_pending,
   input wire logic ext_irq_ack,
   output logic [23:0] port_dir,
   output logic port_c_line_two_out,
   output logic port_c_line_two_oe,
   output logic adc_enable,
   output logic core_reset_n
);
   logic [7:0] misc_q;
   logic [23:0] port_dir_q;
   logic [1:0] aux_q;
   logic [2:0] status_q;
   logic [2:0] mask_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic irq_s1_q, irq_s2_q, rst_s1_q, rst_s2_q;
   logic [12:0] stab_cnt_q;
   logic [2:0] pulse_cnt_q;
   logic pending;
   logic pending_q;
   logic mode_change;
   logic wr_hit, rd_hit;
   logic [2:0] events;
   trig_mode_t new_mode;

   typedef enum logic [2:0] {
      st_run = 3'b001,
      st_halt = 3'b010,
      st_stab = 3'b100
   } pwr_state_t;
   pwr_state_t pwr_q;

   bus_clk_if clk_bus();

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_s1_q <= 1'b1;
         irq_s2_q <= 1'b1;
         rst_s1_q <= 1'b1;
         rst_s2_q <= 1'b1;
      end else begin
         irq_s1_q <= irq_pin_n;
         irq_s2_q <= irq_s1_q;
         rst_s1_q <= reset_pin_n_in;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Internal reset held while board or watchdog asserts it
   assign core_reset_n = rst_s2_q && (pulse_cnt_q == 3'h0);

   // Watchdog stretches an open-drain low pulse on the reset pin
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pulse_cnt_q <= 3'h0;
      end else if (watchdog_fault) begin
         pulse_cnt_q <= 3'(reset_pulse_cycles);
      end else if (pulse_cnt_q != 3'h0) begin
         pulse_cnt_q <= pulse_cnt_q - 3'h1;
      end
   end
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = (pulse_cnt_q != 3'h0);

   // One wait cycle: writes land on the accepting edge, reads fetch a cycle early
   assign wr_hit = avs_write && ack_q;
   assign rd_hit = avs_read && !ack_q;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   // Trigger option change honoured only with the cpu mask set
   assign new_mode = trig_mode_t'({avs_writedata[trig_pos_bit], avs_writedata[trig_neg_bit]});
   assign mode_change = wr_hit && avs_byteenable[0] && (avs_address == misc_offset) && cpu_irq_masked
      && (new_mode != trig_mode_t'({misc_q[trig_pos_bit], misc_q[trig_neg_bit]}));

   // Miscellaneous register; resets clear slow bit, halt clears it too
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         misc_q <= misc_reset;
      end else if (!core_reset_n) begin
         misc_q <= misc_reset;
      end else if (halt_req && pwr_q == st_run) begin
         misc_q[slow_bit] <= 1'b0;
      end else if (wr_hit && avs_byteenable[0] && avs_address == misc_offset) begin
         misc_q[irq_allow_bit:watchdog_control_bit_bit] <= avs_writedata[irq_allow_bit:watchdog_control_bit_bit];
         if (cpu_irq_masked) begin
            misc_q[trig_pos_bit] <= avs_writedata[trig_pos_bit];
            misc_q[trig_neg_bit] <= avs_writedata[trig_neg_bit];
         end
      end
   end

   // Port direction and aux control; all inputs, converter off at reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         port_dir_q <= port_dir_reset;
         aux_q <= 2'b00;
      end else if (!core_reset_n) begin
         port_dir_q <= port_dir_reset;
         aux_q <= 2'b00;
      end else if (wr_hit && avs_address == port_dir_offset) begin
         for (int b = 0; b < 3; b++) begin
            if (avs_byteenable[b]) begin
               port_dir_q[b*8 +: 8] <= avs_writedata[b*8 +: 8];
            end
         end
      end else if (wr_hit && avs_byteenable[0] && avs_address == aux_ctrl_offset) begin
         aux_q <= avs_writedata[1:0];
      end
   end
   assign port_dir = port_dir_q;
   assign adc_enable = aux_q[1];
   // Bit 0 routes the bus clock to the port C line two pin
   assign port_c_line_two_out = clk_bus.bus_clk_level;
   assign port_c_line_two_oe = aux_q[0] || port_dir_q[16 + 2];

   // Deep halt: clock frozen, then nominal-speed stabilisation count
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pwr_q <= st_run;
         stab_cnt_q <= 13'h0000;
      end else begin
         unique case (pwr_q)
            st_run: begin
               if (halt_req) begin
                  pwr_q <= st_halt;
               end
            end
            st_halt: begin
               if (wake_req || !core_reset_n) begin
                  pwr_q <= st_stab;
                  stab_cnt_q <= 13'(stab_cycles - 1);
               end
            end
            st_stab: begin
               if (stab_cnt_q == 13'h0000) begin
                  pwr_q <= st_run;
               end else begin
                  stab_cnt_q <= stab_cnt_q - 13'h0001;
               end
            end
         endcase
      end
   end
   assign halted = (pwr_q != st_run);

   // One divider feeds every section through bus_tick
   assign clk_bus.slow_sel = misc_q[slow_bit];
   assign clk_bus.halt = (pwr_q != st_run);
   assign bus_tick = clk_bus.bus_tick;
   assign bus_clk_level = clk_bus.bus_clk_level;

   bus_clk_div u_div (
      .core_clk(core_clk),
      .resetn(resetn),
      .clk_bus(clk_bus)
   );

   irq_trigger u_trig (
      .core_clk(core_clk),
      .resetn(resetn),
      .pin_n(irq_s2_q),
      .allow(misc_q[irq_allow_bit]),
      .mode(trig_mode_t'({misc_q[trig_pos_bit], misc_q[trig_neg_bit]})),
      .mode_change(mode_change),
      .ack(ext_irq_ack),
      .pending(pending)
   );
   assign ext_irq_pending = pending;

   // Previous pending level; status takes the rise, so a read can clear it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pending_q <= 1'b0;
      end else begin
         pending_q <= pending;
      end
   end

   // Sticky event status, read clears; a new event wins over the clear
   assign events = {(pwr_q == st_stab) && (stab_cnt_q == 13'h0000), watchdog_fault, pending && !pending_q};
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= status_reset;
         mask_q <= status_reset;
      end else begin
         if (rd_hit && avs_address == status_offset) begin
            status_q <= events;
         end else begin
            status_q <= status_q | events;
         end
         if (wr_hit && avs_byteenable[0] && avs_address == mask_offset) begin
            mask_q <= avs_writedata[2:0];
         end
      end
   end
   assign irq = |(status_q & mask_q);

   // Read data registered; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h00000000;
      end else if (rd_hit) begin
         unique case (avs_address)
            misc_offset: rdata_q <= {24'h000000, misc_q};
            status_offset: rdata_q <= {29'h00000000, status_q};
            mask_offset: rdata_q <= {29'h00000000, mask_q};
            port_dir_offset: rdata_q <= {8'h00, port_dir_q};
            aux_ctrl_offset: rdata_q <= {30'h00000000, aux_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end
   assign avs_readdata = rdata_q;

   chk_halt_clears_slow: assert property (@(posedge core_clk) disable iff (!resetn)
      (halt_req && pwr_q == st_run && core_reset_n) |=> !misc_q[slow_bit])
      else $error("slow bit survived halt entry");
   chk_trig_locked: assert property (@(posedge core_clk) disable iff (!resetn)
      !cpu_irq_masked |=> $stable(misc_q[trig_pos_bit:trig_neg_bit]) || !$past(core_reset_n))
      else $error("trigger bits changed while unmasked");
   chk_watchdog_control_bit_pin: assert property (@(posedge core_clk) disable iff (!resetn)
      watchdog_fault |=> reset_pin_oe [*4])
      else $error("reset pin not driven after watchdog");
   chk_reset_dirs: assert property (@(posedge core_clk) disable iff (!resetn)
      !core_reset_n |=> port_dir == 24'h000000 && !adc_enable)
      else $error("ports not input after reset");
   chk_allow_gate: assert property (@(posedge core_clk) disable iff (!resetn)
      !misc_q[irq_allow_bit] |=> !pending)
      else $error("irq pending while disabled");
   chk_halt_tick: assert property (@(posedge core_clk) disable iff (!resetn)
      halted |-> !bus_tick)
      else $error("bus tick during halt");

   // Start-up, halt-exit, event-status and clock-out guards
   chk_pin_reset_slow: assert property (@(posedge core_clk) disable iff (!resetn)
      !core_reset_n |=> !misc_q[slow_bit])
      else $error("slow bit survived pin reset");
   chk_stab_start: assert property (@(posedge core_clk) disable iff (!resetn)
      (pwr_q == st_halt && wake_req) |=> (pwr_q == st_stab && stab_cnt_q == 13'(stab_cycles - 1)))
      else $error("stabilisation count not loaded on wake");
   chk_event_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
      (pending && !pending_q) |=> status_q[ev_ext_irq])
      else $error("external irq event not recorded");
   chk_clock_out: assert property (@(posedge core_clk) disable iff (!resetn)
      aux_q[0] |-> (port_c_line_two_oe && port_c_line_two_out == bus_clk_level))
      else $error("bus clock not routed to port pin");
endmodule

// ---- misc_ctrl_pkg.sv ----
// Package for the bus clock and interrupt configuration block.
// Assumes a single core_clk domain standing in for the oscillator.
package misc_ctrl_pkg;
   // Register map (byte addresses, one aligned word each)
   localparam logic [5:0] misc_offset = 6'h0C;
   localparam logic [5:0] status_offset = 6'h10;
   localparam logic [5:0] mask_offset = 6'h14;
   localparam logic [5:0] port_dir_offset = 6'h18;
   localparam logic [5:0] aux_ctrl_offset = 6'h1C;
   // Field positions of the miscellaneous register
   localparam int trig_pos_bit = 6;
   localparam int trig_neg_bit = 5;
   localparam int irq_allow_bit = 4;
   localparam int spare_a_bit = 3;
   localparam int spare_b_bit = 2;
   localparam int slow_bit = 1;
   localparam int watchdog_control_bit_bit = 0;
   // Reset values
   localparam logic [7:0] misc_reset = 8'h10;
   localparam logic [23:0] port_dir_reset = 24'h000000;
   localparam logic [2:0] status_reset = 3'h0;
   // Status/mask bit positions
   localparam int ev_ext_irq = 0;
   localparam int ev_int_reset = 1;
   localparam int ev_halt_wake = 2;
   // Timing counts in oscillator cycles
   localparam int normal_div = 2;
   localparam int slow_div = 32;
   localparam int slow_ratio = 16;
   localparam int stab_cycles = 4064;
   localparam int reset_pulse_cycles = 4;
   // Trigger options
   typedef enum logic [1:0] {
      trig_low_level = 2'b00,
      trig_neg_edge = 2'b01,
      trig_pos_edge = 2'b10,
      trig_both_edge = 2'b11
   } trig_mode_t;
endpackage

// ---- bus_clk_if.sv ----
// Interface carrying the bus clock enables from divider to core logic.
// Assumes both ends sit on core_clk.
interface bus_clk_if;
   logic slow_sel;
   logic halt;
   logic bus_tick;
   logic bus_clk_level;
   modport divider (input slow_sel, input halt, output bus_tick, output bus_clk_level);
   modport user (output slow_sel, output halt, input bus_tick, input bus_clk_level);
endinterface

// ---- bus_clk_div.sv ----
// Bus clock divider: osc/2 normally, osc/32 in slow mode.
// Assumes core_clk is the oscillator; switching only at period ends.
module bus_clk_div
   import misc_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   bus_clk_if.divider clk_bus
);
   logic [4:0] cnt_q;
   logic div_mode_q;
   logic level_q;
   logic [4:0] last_cnt;
   logic period_end;

   // Mode is only sampled at a period end, so no runt phase appears
   assign last_cnt = div_mode_q ? 5'(slow_div - 1) : 5'(normal_div - 1);
   assign period_end = (cnt_q == last_cnt);
   assign clk_bus.bus_tick = period_end && !clk_bus.halt;
   assign clk_bus.bus_clk_level = level_q;

   // Phase counter, frozen while halted
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 5'h00;
      end else if (!clk_bus.halt) begin
         cnt_q <= period_end ? 5'h00 : cnt_q + 5'h01;
      end
   end

   // Divide ratio latched at boundary only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div_mode_q <= 1'b0;
      end else if (period_end) begin
         div_mode_q <= clk_bus.slow_sel;
      end
   end

   // High in the first half of each bus period
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         level_q <= 1'b0;
      end else begin
         level_q <= (cnt_q < (last_cnt >> 1)) || period_end;
      end
   end

   chk_no_runt_switch: assert property (@(posedge core_clk) disable iff (!resetn)
      !$past(period_end) |-> $stable(div_mode_q))
      else $error("divide ratio changed mid period");
   chk_slow_period: assert property (@(posedge core_clk) disable iff (!resetn)
      (period_end && div_mode_q && !clk_bus.halt) |-> ##1 (!period_end)[*8])
      else $error("slow period too short");
endmodule

// ---- irq_trigger.sv ----
// External interrupt pin detector with four trigger options.
// Assumes pin already synchronised to core_clk.
module irq_trigger
   import misc_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic pin_n,
   input wire logic allow,
   input wire trig_mode_t mode,
   input wire logic mode_change,
   input wire logic ack,
   output logic pending
);
   logic prev_q;
   logic hit;

   // Edge/level decode on the active-low pin
   always_comb begin
      unique case (mode)
         trig_low_level: hit = !pin_n;
         trig_neg_edge: hit = prev_q && !pin_n;
         trig_pos_edge: hit = !prev_q && pin_n;
         trig_both_edge: hit = prev_q != pin_n;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b1;
      end else begin
         prev_q <= pin_n;
      end
   end

   // Pending latch; option change flushes it, new hit still wins over ack
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pending <= 1'b0;
      end else if (mode_change || !allow) begin
         pending <= 1'b0;
      end else if (hit) begin
         pending <= 1'b1;
      end else if (ack) begin
         pending <= 1'b0;
      end
   end

   chk_change_flushes: assert property (@(posedge core_clk) disable iff (!resetn)
      mode_change |=> !pending)
      else $error("pending irq survived option change");
endmodule

// ---- test_misc_ctrl.sv ----
// Testbench for misc_ctrl: register access, bus clock rates, trigger modes.
// Assumes the design's package, interface and divider/trigger modules.
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_misc_ctrl
   import misc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 0, resetn = 0, avs_read = 0, avs_write = 0;
   logic [5:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, d;
   logic avs_waitrequest, irq, irq_pin_n = 1, reset_pin_n_in = 1, reset_pin_out, reset_pin_oe;
   logic cpu_irq_masked = 1, halt_req = 0, wake_req = 0, watchdog_fault = 0, bus_tick, bus_clk_level;
   logic halted, ext_irq_pending, ext_irq_ack = 0, port_c_line_two_out, port_c_line_two_oe, adc_enable;
   logic core_reset_n;
   logic [23:0] port_dir;
   int errors = 0, n_compared = 0, g, k;
   logic [1:0] m;
   misc_ctrl uut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .irq_pin_n(irq_pin_n),
      .reset_pin_n_in(reset_pin_n_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
      .cpu_irq_masked(cpu_irq_masked), .halt_req(halt_req), .wake_req(wake_req),
      .watchdog_fault(watchdog_fault), .bus_tick(bus_tick), .bus_clk_level(bus_clk_level),
      .halted(halted), .ext_irq_pending(ext_irq_pending), .ext_irq_ack(ext_irq_ack), .port_dir(port_dir),
      .port_c_line_two_out(port_c_line_two_out), .port_c_line_two_oe(port_c_line_two_oe),
      .adc_enable(adc_enable), .core_reset_n(core_reset_n));
   // Oscillator stand-in
   always #12.5 core_clk = ~core_clk;
   // Verdict and end of run
   task automatic results();
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Bus cycle: hold request until waitrequest is seen low at an edge
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      if (n >= 50) errors++;
      avs_write <= 0;
      avs_read <= 0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] wd);
      logic [31:0] x;
      xfer(1'b1, a, wd, x);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] x);
      xfer(1'b0, a, 32'h0, x);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // One-cycle pulse: 0 halt, 1 wake, 2 irq ack, else watchdog
   // Picked by index, since a ref argument cannot take a non-blocking write
   task automatic pulse(input int sel);
      @(posedge core_clk);
      case (sel)
         0: halt_req <= 1;
         1: wake_req <= 1;
         2: ext_irq_ack <= 1;
         default: watchdog_fault <= 1;
      endcase
      @(posedge core_clk);
      {halt_req, wake_req, ext_irq_ack, watchdog_fault} <= 4'h0;
   endtask
   // Cycles between two bus ticks, checked at settled points
   task automatic tick_gap(output int gap);
      int i;
      @(negedge core_clk);
      for (i = 0; i < 200 && bus_tick !== 1'b1; i++) @(negedge core_clk);
      @(negedge core_clk);
      gap = 1;
      while (bus_tick !== 1'b1 && gap < 200) begin
         @(negedge core_clk);
         gap++;
      end
   endtask
   // Bounded guard; the full sequence needs well under 10000 cycles
   initial begin
      #1ms;
      errors++;
      results();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      resetn <= 1;
      // Reset state of the register file and pins
      rd(misc_offset, d); `CHK(d[7:0], misc_reset)
      rd(port_dir_offset, d); `CHK(d[23:0], 24'h000000)
      `CHK(port_dir, 24'h000000)
      `CHK(adc_enable, 1'b0)
      `CHK({irq, reset_pin_oe}, 2'b00)
      rd(6'h3C, d); `CHK(d, 32'h00000000)
      // Normal then slow bus rate; the switch lands on a period boundary
      tick_gap(g); `CHK(g, normal_div)
      wr(misc_offset, 32'h12);
      tick_gap(g);
      tick_gap(g); `CHK(g, slow_div)
      tick_gap(g); `CHK(g, normal_div * slow_ratio)
      rd(misc_offset, d); `CHK(d[slow_bit], 1'b1)
      // Deep halt clears slow mode; wake runs the stabilisation count
      pulse(0);
      cyc(3); `CHK(halted, 1'b1)
      rd(misc_offset, d); `CHK(d[slow_bit], 1'b0)
      pulse(1);
      k = 0;
      while (halted === 1'b1 && k < 6000) begin
         @(negedge core_clk);
         k++;
      end
      `CHK(k >= stab_cycles - 2 && k <= stab_cycles + 8, 1'b1)
      tick_gap(g); `CHK(g, normal_div)
      rd(status_offset, d); `CHK(d[ev_halt_wake], 1'b1)
      rd(status_offset, d); `CHK(d[2:0], 3'h0)
      // All four trigger options; one table of expected pending states
      for (int i = 0; i < 4; i++) begin
         m = 2'(i + 1);
         wr(misc_offset, 32'(m) << trig_neg_bit | 32'h10);
         pulse(2);
         rd(misc_offset, d); `CHK(d[6:5], m)
         irq_pin_n <= 0;
         cyc(6); `CHK(ext_irq_pending, m != 2'b10)
         pulse(2);
         cyc(3); `CHK(ext_irq_pending, m == 2'b00)
         irq_pin_n <= 1;
         cyc(6); `CHK(ext_irq_pending, m != 2'b01)
         pulse(2);
      end
      // Trigger bits locked while the cpu mask is clear
      cpu_irq_masked <= 0;
      wr(misc_offset, 32'h70);
      rd(misc_offset, d); `CHK(d[7:4], 4'h1)
      cpu_irq_masked <= 1;
      // Interrupt raised, read-cleared, then masked off
      wr(mask_offset, 32'h1);
      wr(misc_offset, 32'h30);
      rd(status_offset, d);
      irq_pin_n <= 0;
      cyc(6); `CHK({ext_irq_pending, irq}, 2'b11)
      rd(status_offset, d); `CHK(d[ev_ext_irq], 1'b1)
      cyc(1); `CHK(irq, 1'b0)
      // A new option drops the pending request
      wr(misc_offset, 32'h50);
      cyc(2); `CHK(ext_irq_pending, 1'b0)
      irq_pin_n <= 1;
      cyc(6);
      pulse(2);
      wr(mask_offset, 32'h0);
      wr(misc_offset, 32'h30);
      rd(status_offset, d);
      irq_pin_n <= 0;
      cyc(6); `CHK({ext_irq_pending, irq}, 2'b10)
      pulse(2);
      irq_pin_n <= 1;
      // Facility disabled: an edge leaves nothing pending
      wr(misc_offset, 32'h20);
      irq_pin_n <= 0;
      cyc(6); `CHK(ext_irq_pending, 1'b0)
      irq_pin_n <= 1;
      // Port direction, clock out on port C line two, converter enable
      // Line 18 left an input so only the aux bit can enable the pin
      wr(port_dir_offset, 32'hFBFFFF);
      cyc(1); `CHK(port_dir, 24'hFBFFFF)
      wr(aux_ctrl_offset, 32'h3);
      cyc(2); `CHK({port_c_line_two_oe, adc_enable}, 2'b11)
      // Normal rate: the routed bus clock flips every oscillator cycle
      for (int i = 0; i < 4; i++) begin
         m[0] = port_c_line_two_out;
         cyc(1); `CHK(port_c_line_two_out, !m[0])
      end
      // Watchdog drives the reset pin low for the fixed pulse
      pulse(3);
      k = 0;
      for (int i = 0; i < 20; i++) begin
         cyc(1);
         if (reset_pin_oe === 1'b1 && reset_pin_out === 1'b0) k++;
      end
      `CHK(k, reset_pulse_cycles)
      rd(status_offset, d); `CHK(d[ev_int_reset], 1'b1)
      // Board pin reset reloads the start-up state after slow mode, port directions and clock out are set
      wr(misc_offset, 32'h1E);
      wr(port_dir_offset, 32'h00FF00);
      wr(aux_ctrl_offset, 32'h1);
      cyc(1); `CHK({port_dir, port_c_line_two_oe}, 25'h01FE01)
      @(posedge core_clk);
      reset_pin_n_in <= 0;
      cyc(4); `CHK(core_reset_n, 1'b0)
      @(posedge core_clk);
      reset_pin_n_in <= 1;
      cyc(6);
      rd(misc_offset, d); `CHK(d[7:0], misc_reset)
      `CHK({port_dir, adc_enable, port_c_line_two_oe}, 26'h0)
      results();
   end
endmodule
